// File: nvp_pkg.sv
// package for the nvm page programming controller: constants, types, function list
// Function
// RULE1: flash split into three 256-byte-granular sections
// RULE2: loader, program, storage bounds from end fuses
// RULE3: zero fuses extend program or loader section
// RULE4: writes only downward: loader, program, storage
// RULE5: storage-section code may not write anything
// RULE6: locks block section updates until reset
// RULE7: loader never written; lock blocks its reads
// RULE8: eeprom erase/write only on marked bytes
// RULE9: user row survives chip erase, debug writable
// RULE10: array reads wait while operation busy
// RULE11: one shared page buffer, low address bits
// RULE12: buffer store ANDs new with old content
// RULE13: buffer all ones after reset, op, clear, wake
// RULE14: command accepted only within key window
// RULE15: page write stalls cpu only for flash
// RULE16: erase needs a marked byte first
// RULE17: flash erase halts cpu; buffer cleared after
// RULE18: erase-write erases then programs, clears at end
// RULE19: buffer clear halts cpu seven cycles
// RULE20: chip erase spares eeprom if keep fuse
// RULE21: eeprom erase halts cpu until done
// RULE22: fuse write only from debug port
// RULE23: reset aborts an ongoing write
// RULE24: three-bit command encoding zero to seven
// RULE25: self-program key unlocks commands
// RULE26: status gives write error and busy flags
// RULE27: page and flash size are parameters
// RULE28: commands ignored while an operation is busy
package nvp_pkg;
  localparam int NVP_SECT_SHIFT = 8;
  localparam logic [7:0] NVP_SPM_KEY = 8'h9d;
  localparam logic [2:0] NVP_KEY_WINDOW = 3'h4;
  localparam logic [3:0] NVP_PBC_CYCLES = 4'h7;
  localparam logic [7:0] NVP_ERASED = 8'hff;
  localparam logic [1:0] NVP_TGT_FLASH = 2'h0;
  localparam logic [1:0] NVP_TGT_EEPROM = 2'h1;
  localparam logic [1:0] NVP_TGT_USER = 2'h2;

  typedef enum logic [2:0] {
    NVP_CMD_NONE = 3'h0,
    NVP_CMD_WRITE = 3'h1,
    NVP_CMD_ERASE = 3'h2,
    NVP_CMD_ERASE_WRITE = 3'h3,
    NVP_CMD_BUF_CLEAR = 3'h4,
    NVP_CMD_CHIP_ERASE = 3'h5,
    NVP_CMD_EE_ERASE = 3'h6,
    NVP_CMD_FUSE_WRITE = 3'h7
  } nvp_cmd_t;

  typedef enum logic [1:0] {
    NVP_SEC_LOADER,
    NVP_SEC_PROGRAM,
    NVP_SEC_STORAGE
  } nvp_sec_t;

  // request to the array macro
  typedef struct packed {
    logic erase;
    logic write;
    logic chip;
    logic keep_eeprom;
    logic [1:0] target;
    logic [15:0] addr;
  } nvp_array_req_t;

  // status seen by software
  typedef struct packed {
    logic write_error_flag;
    logic eeprom_busy_flag;
    logic flash_busy_flag;
  } nvp_status_t;
endpackage : nvp_pkg

// File: nvp_section.sv
// section decoder: maps a flash address to its protection section
`timescale 1ns/1ps
module nvp_section
  import nvp_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] loader_end_fuse,
  input wire logic [7:0] program_end_fuse,
  output nvp_sec_t section
);
  logic [ADDR_W-1:0] loader_top;
  logic [ADDR_W-1:0] program_top;

  // section bounds in 256-byte blocks
  assign loader_top = ADDR_W'({loader_end_fuse, 8'h00}); // RULE1
  assign program_top = ADDR_W'({program_end_fuse, 8'h00}); // RULE2

  always_comb begin
    if (loader_end_fuse == 8'h00 || addr < loader_top) begin
      section = NVP_SEC_LOADER; // RULE3
    end else if (program_end_fuse == 8'h00 || addr < program_top) begin
      section = NVP_SEC_PROGRAM; // RULE3
    end else begin
      section = NVP_SEC_STORAGE; // RULE2
    end
  end
endmodule : nvp_section

// File: nvp_ctrl.sv
// nvm page programming controller: page buffer, protection, command sequencer
`timescale 1ns/1ps
module nvp_ctrl
  import nvp_pkg::*;
#(
  parameter int PAGE_BYTES = 64,
  parameter int ADDR_W = 16,
  parameter int FLASH_OP_CYCLES = 64,
  parameter int EE_OP_CYCLES = 32,
  parameter int CHIP_OP_CYCLES = 256
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] loader_end_fuse,
  input wire logic [7:0] program_end_fuse,
  input wire logic keep_eeprom_on_full_erase,
  input wire logic device_locked,
  input wire logic wake_event,
  input wire logic ccp_wr,
  input wire logic [7:0] ccp_wdata,
  input wire logic instr_retire,
  input wire logic cmd_wr,
  input wire logic [2:0] cmd_wdata,
  input wire logic cmd_from_debug,
  input wire logic lock_wr,
  input wire logic [1:0] lock_wdata,
  input wire logic st_valid,
  input wire logic [ADDR_W-1:0] st_addr,
  input wire logic [1:0] st_target,
  input wire logic [7:0] st_data,
  input wire logic st_from_debug,
  input wire logic [ADDR_W-1:0] exec_addr,
  input wire logic rd_valid,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic rd_is_flash,
  input wire logic op_done,
  output logic cpu_halt,
  output logic rd_wait,
  output logic rd_blocked,
  output nvp_status_t status,
  output logic [1:0] lock_state,
  output nvp_array_req_t array_req,
  output logic [8*PAGE_BYTES-1:0] page_data,
  output logic [PAGE_BYTES-1:0] page_mark
);
  localparam int IDX_W = $clog2(PAGE_BYTES);

  typedef enum logic [2:0] {
    NVP_IDLE, NVP_ERASE, NVP_WRITE, NVP_CLEAR, NVP_DONE
  } nvp_state_t;

  nvp_state_t state_reg, state_next;
  logic [7:0] buf_reg [PAGE_BYTES];
  logic [7:0] buf_next [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_reg, mark_next;
  logic [1:0] tgt_reg, tgt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  nvp_sec_t sec_reg, sec_next;
  logic any_mark_reg, any_mark_next;
  logic [2:0] key_reg, key_next;
  logic [3:0] clr_cnt_reg, clr_cnt_next;
  logic halt_reg, halt_next;
  logic wait_reg, wait_next;
  logic blk_reg, blk_next;
  logic werr_reg, werr_next;
  logic flash_busy_flag_reg, flash_busy_flag_next;
  logic ebusy_reg, ebusy_next;
  logic prog_lock_reg, prog_lock_next;
  logic boot_lock_reg, boot_lock_next;
  nvp_array_req_t req_reg, req_next;
  nvp_sec_t st_sec, exec_sec, rd_sec;
  logic [IDX_W-1:0] st_idx;
  logic busy, cmd_go, flush, prot_err;

  nvp_section #(.ADDR_W(ADDR_W)) u_st_sec (
    .addr(st_addr), .loader_end_fuse(loader_end_fuse),
    .program_end_fuse(program_end_fuse), .section(st_sec));
  nvp_section #(.ADDR_W(ADDR_W)) u_exec_sec (
    .addr(exec_addr), .loader_end_fuse(loader_end_fuse),
    .program_end_fuse(program_end_fuse), .section(exec_sec));
  nvp_section #(.ADDR_W(ADDR_W)) u_rd_sec (
    .addr(rd_addr), .loader_end_fuse(loader_end_fuse),
    .program_end_fuse(program_end_fuse), .section(rd_sec));

  assign st_idx = st_addr[IDX_W-1:0]; // RULE11 RULE27
  assign busy = state_reg != NVP_IDLE;
  // key window open and legal source
  assign cmd_go = cmd_wr && (key_reg != 3'h0 || cmd_from_debug) && !busy; // RULE14 RULE28

  // protection check for the pending page operation
  always_comb begin
    prot_err = 1'b0;
    if (!cmd_from_debug) begin
      if (exec_sec == NVP_SEC_STORAGE) begin
        prot_err = 1'b1; // RULE5
      end else if (tgt_reg == NVP_TGT_FLASH) begin
        if (sec_reg == NVP_SEC_LOADER) begin
          prot_err = 1'b1; // RULE7
        end else if (sec_reg == NVP_SEC_PROGRAM) begin
          prot_err = exec_sec != NVP_SEC_LOADER || prog_lock_reg; // RULE4 RULE6
        end else begin
          prot_err = 1'b0; // RULE4
        end
      end else if (tgt_reg == NVP_TGT_USER && device_locked) begin
        prot_err = 1'b1; // RULE9
      end
    end
  end

  // key window, locks, sequencer and status
  always_comb begin
    state_next = state_reg;
    key_next = key_reg;
    clr_cnt_next = clr_cnt_reg;
    halt_next = halt_reg;
    werr_next = werr_reg;
    flash_busy_flag_next = flash_busy_flag_reg;
    ebusy_next = ebusy_reg;
    prog_lock_next = prog_lock_reg;
    boot_lock_next = boot_lock_reg;
    req_next = req_reg;
    flush = 1'b0;
    if (ccp_wr && ccp_wdata == NVP_SPM_KEY) begin
      key_next = NVP_KEY_WINDOW; // RULE25
    end else if (instr_retire && key_reg != 3'h0) begin
      key_next = key_reg - 3'h1; // RULE14
    end
    if (lock_wr) begin
      prog_lock_next = prog_lock_reg | lock_wdata[0]; // RULE6
      if (exec_sec == NVP_SEC_LOADER) begin
        boot_lock_next = boot_lock_reg | lock_wdata[1]; // RULE6
      end
    end
    unique case (state_reg)
      NVP_IDLE: begin
        if (cmd_go) begin
          key_next = 3'h0;
          werr_next = 1'b0;
          req_next.target = tgt_reg;
          req_next.addr = addr_reg;
          req_next.keep_eeprom = keep_eeprom_on_full_erase;
          req_next.chip = 1'b0;
          req_next.erase = 1'b0;
          req_next.write = 1'b0;
          unique case (nvp_cmd_t'(cmd_wdata)) // RULE24
            NVP_CMD_WRITE, NVP_CMD_ERASE, NVP_CMD_ERASE_WRITE: begin
              if (prot_err) begin
                werr_next = 1'b1; // RULE26
              end else if (cmd_wdata == NVP_CMD_WRITE) begin
                req_next.write = 1'b1;
                state_next = NVP_WRITE;
              end else if (any_mark_reg) begin // RULE16
                req_next.erase = 1'b1;
                state_next = cmd_wdata == NVP_CMD_ERASE ? NVP_ERASE : NVP_CLEAR;
              end
              if (!prot_err && (cmd_wdata == NVP_CMD_WRITE || any_mark_reg)) begin
                halt_next = tgt_reg == NVP_TGT_FLASH; // RULE15 RULE17
                flash_busy_flag_next = tgt_reg == NVP_TGT_FLASH; // RULE26
                ebusy_next = tgt_reg != NVP_TGT_FLASH;
              end
            end
            NVP_CMD_BUF_CLEAR: begin
              clr_cnt_next = NVP_PBC_CYCLES; // RULE19
              halt_next = 1'b1;
              state_next = NVP_DONE;
            end
            NVP_CMD_CHIP_ERASE, NVP_CMD_EE_ERASE: begin
              req_next.erase = 1'b1;
              req_next.chip = cmd_wdata == NVP_CMD_CHIP_ERASE; // RULE20
              req_next.target = cmd_wdata == NVP_CMD_CHIP_ERASE ? NVP_TGT_FLASH
                                                                : NVP_TGT_EEPROM;
              halt_next = 1'b1; // RULE21
              flash_busy_flag_next = cmd_wdata == NVP_CMD_CHIP_ERASE;
              ebusy_next = 1'b1;
              state_next = NVP_ERASE;
            end
            NVP_CMD_FUSE_WRITE: begin
              if (cmd_from_debug) begin // RULE22
                req_next.write = 1'b1;
                state_next = NVP_WRITE;
              end else begin
                werr_next = 1'b1;
              end
            end
            NVP_CMD_NONE: begin
            end
          endcase
        end
      end
      NVP_CLEAR: begin
        // erase phase of erase-write, buffer kept
        if (op_done) begin
          req_next.erase = 1'b0; // RULE18
          req_next.write = 1'b1;
          state_next = NVP_WRITE;
        end
      end
      NVP_ERASE, NVP_WRITE: begin
        if (op_done) begin
          req_next.erase = 1'b0;
          req_next.write = 1'b0;
          req_next.chip = 1'b0;
          flush = 1'b1; // RULE13 RULE17 RULE18
          halt_next = 1'b0;
          flash_busy_flag_next = 1'b0; // RULE28
          ebusy_next = 1'b0;
          state_next = NVP_IDLE;
        end
      end
      NVP_DONE: begin
        if (clr_cnt_reg == 4'h1) begin
          flush = 1'b1; // RULE19
          halt_next = 1'b0;
          state_next = NVP_IDLE;
        end
        clr_cnt_next = clr_cnt_reg - 4'h1;
      end
      default: state_next = NVP_IDLE;
    endcase
  end

  // page buffer loading with and-merge and byte marks
  always_comb begin
    tgt_next = tgt_reg;
    addr_next = addr_reg;
    sec_next = sec_reg;
    any_mark_next = any_mark_reg;
    mark_next = mark_reg;
    for (int i = 0; i < PAGE_BYTES; i++) begin
      buf_next[i] = buf_reg[i];
    end
    if (flush || wake_event) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_next[i] = NVP_ERASED; // RULE13
      end
      mark_next = '0;
      any_mark_next = 1'b0;
    end else if (st_valid && !busy) begin
      buf_next[st_idx] = buf_reg[st_idx] & st_data; // RULE12
      mark_next[st_idx] = 1'b1; // RULE8
      any_mark_next = 1'b1; // RULE16
      tgt_next = st_target; // RULE11
      addr_next = st_addr;
      sec_next = st_sec;
      if (st_from_debug) begin
        sec_next = NVP_SEC_STORAGE;
      end
    end
  end

  // read wait and loader read block
  always_comb begin
    wait_next = rd_valid && busy && state_reg != NVP_DONE; // RULE10
    blk_next = rd_valid && rd_is_flash && boot_lock_reg &&
               rd_sec == NVP_SEC_LOADER && exec_sec != NVP_SEC_LOADER; // RULE7
  end

  // async reset aborts any operation
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= NVP_IDLE; // RULE23
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_reg[i] <= NVP_ERASED; // RULE13
      end
      mark_reg <= '0;
      tgt_reg <= NVP_TGT_FLASH;
      addr_reg <= '0;
      sec_reg <= NVP_SEC_LOADER;
      any_mark_reg <= 1'b0;
      key_reg <= 3'h0;
      clr_cnt_reg <= 4'h0;
      halt_reg <= 1'b0;
      wait_reg <= 1'b0;
      blk_reg <= 1'b0;
      werr_reg <= 1'b0;
      flash_busy_flag_reg <= 1'b0;
      ebusy_reg <= 1'b0;
      prog_lock_reg <= 1'b0;
      boot_lock_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_reg[i] <= buf_next[i];
      end
      mark_reg <= mark_next;
      tgt_reg <= tgt_next;
      addr_reg <= addr_next;
      sec_reg <= sec_next;
      any_mark_reg <= any_mark_next;
      key_reg <= key_next;
      clr_cnt_reg <= clr_cnt_next;
      halt_reg <= halt_next;
      wait_reg <= wait_next;
      blk_reg <= blk_next;
      werr_reg <= werr_next;
      flash_busy_flag_reg <= flash_busy_flag_next;
      ebusy_reg <= ebusy_next;
      prog_lock_reg <= prog_lock_next;
      boot_lock_reg <= boot_lock_next;
      req_reg <= req_next;
    end
  end

  // outputs straight from flops
  assign cpu_halt = halt_reg;
  assign rd_wait = wait_reg;
  assign rd_blocked = blk_reg;
  assign status = '{write_error_flag: werr_reg, eeprom_busy_flag: ebusy_reg,
                    flash_busy_flag: flash_busy_flag_reg};
  assign lock_state = {boot_lock_reg, prog_lock_reg};
  assign array_req = req_reg;
  assign page_mark = mark_reg;
  genvar g;
  generate
    for (g = 0; g < PAGE_BYTES; g++) begin : g_pd
      assign page_data[8*g +: 8] = buf_reg[g];
    end
  endgenerate

  // checks
  a_clear_seven: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == NVP_IDLE && cmd_go && cmd_wdata == NVP_CMD_BUF_CLEAR)
    |=> cpu_halt [*7] ##1 !cpu_halt) else $error("buffer clear halt not seven cycles"); // RULE19
  a_and_merge: assert property (@(posedge core_clk) disable iff (!resetn)
    (st_valid && !busy && !flush && !wake_event)
    |=> buf_reg[$past(st_idx)] == ($past(buf_reg[st_idx]) & $past(st_data)))
    else $error("buffer store not and-merged"); // RULE12
  a_busy_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    (busy && state_reg != NVP_DONE && !op_done) |=> $stable(req_reg))
    else $error("request changed while busy"); // RULE28
  a_no_key_cmd: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == NVP_IDLE && cmd_wr && key_reg == 3'h0 && !cmd_from_debug)
    |=> state_reg == NVP_IDLE) else $error("command accepted without key"); // RULE14
  a_fuse_cpu: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == NVP_IDLE && cmd_wr && cmd_wdata == NVP_CMD_FUSE_WRITE && !cmd_from_debug)
    |=> state_reg == NVP_IDLE) else $error("fuse write from cpu"); // RULE22
  a_flush_ones: assert property (@(posedge core_clk) disable iff (!resetn)
    flush |=> page_mark == '0 && buf_reg[0] == NVP_ERASED)
    else $error("buffer not all ones after flush"); // RULE13
  a_read_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_valid && (state_reg == NVP_WRITE || state_reg == NVP_ERASE)) |=> rd_wait)
    else $error("read not waited while busy"); // RULE10
  a_storage_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_reg == NVP_IDLE && cmd_go && exec_sec == NVP_SEC_STORAGE && !cmd_from_debug
     && cmd_wdata == NVP_CMD_WRITE) |=> werr_reg && state_reg == NVP_IDLE)
    else $error("storage code wrote"); // RULE5
  c_page_write: cover property (@(posedge core_clk) state_reg == NVP_WRITE && op_done);
  c_erase_write: cover property (@(posedge core_clk) state_reg == NVP_CLEAR && op_done);
  c_buf_clear: cover property (@(posedge core_clk) state_reg == NVP_DONE);
endmodule : nvp_ctrl

// File: nvp_array_model.sv
// array macro model: answers each erase or write phase after a set delay
`timescale 1ns/1ps
module nvp_array_model
  import nvp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire nvp_array_req_t array_req,
  input wire logic [7:0] lat,
  output logic op_done
);
  logic [7:0] cnt_reg;
  logic busy;

  // any phase request keeps the macro working
  assign busy = array_req.erase || array_req.write || array_req.chip;

  // count one phase, pulse done for one cycle; reset drops a phase in flight
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
      op_done <= 1'b0;
    end else if (op_done || !busy) begin
      cnt_reg <= 8'h00;
      op_done <= 1'b0;
    end else if (cnt_reg >= lat) begin
      op_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : nvp_array_model

// File: nvp_ctrl_tb.sv
// self-checking bench for the nvm page programming controller
`timescale 1ns/1ps
module nvp_ctrl_tb;
  import nvp_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] loader_end_fuse = 8'h01;
  logic [7:0] program_end_fuse = 8'h02;
  logic keep_eeprom_on_full_erase = 1'b0;
  logic device_locked = 1'b0;
  logic wake_event = 1'b0;
  logic ccp_wr = 1'b0;
  logic [7:0] ccp_wdata = 8'h00;
  logic instr_retire = 1'b0;
  logic cmd_wr = 1'b0;
  logic [2:0] cmd_wdata = 3'h0;
  logic cmd_from_debug = 1'b0;
  logic lock_wr = 1'b0;
  logic [1:0] lock_wdata = 2'h0;
  logic st_valid = 1'b0;
  logic [15:0] st_addr = 16'h0000;
  logic [1:0] st_target = 2'h0;
  logic [7:0] st_data = 8'h00;
  logic st_from_debug = 1'b0;
  logic [15:0] exec_addr = 16'h0010;
  logic rd_valid = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic rd_is_flash = 1'b0;
  logic op_done;
  logic cpu_halt;
  logic rd_wait;
  logic rd_blocked;
  nvp_status_t status;
  logic [1:0] lock_state;
  nvp_array_req_t array_req;
  logic [511:0] page_data;
  logic [63:0] page_mark;
  logic [7:0] lat = 8'h03;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  nvp_ctrl nvp_ctrl_i (
    .core_clk, .resetn, .loader_end_fuse, .program_end_fuse, .keep_eeprom_on_full_erase,
    .device_locked, .wake_event, .ccp_wr, .ccp_wdata, .instr_retire, .cmd_wr, .cmd_wdata,
    .cmd_from_debug, .lock_wr, .lock_wdata, .st_valid, .st_addr, .st_target, .st_data,
    .st_from_debug, .exec_addr, .rd_valid, .rd_addr, .rd_is_flash, .op_done, .cpu_halt,
    .rd_wait, .rd_blocked, .status, .lock_state, .array_req, .page_data, .page_mark
  );
  nvp_array_model nvp_array_model_i (.core_clk, .resetn, .array_req, .lat, .op_done);

  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : ck

  task automatic rst();
    resetn = 1'b0;
    cyc(5);
    resetn = 1'b1;
    cyc(1);
  endtask : rst

  // one buffer store, whole byte
  task automatic st(input logic [15:0] a, input logic [1:0] t, input logic [7:0] d);
    st_addr = a;
    st_target = t;
    st_data = d;
    st_valid = 1'b1;
    cyc(1);
    st_valid = 1'b0;
    cyc(1);
  endtask : st

  // key unless from debug, some retired instructions, then the command
  task automatic cmd(input logic [2:0] c, input int nret, input logic dbg);
    if (!dbg) begin
      ccp_wr = 1'b1;
      ccp_wdata = NVP_SPM_KEY;
      cyc(1);
      ccp_wr = 1'b0;
    end
    repeat (nret) begin
      instr_retire = 1'b1;
      cyc(1);
    end
    instr_retire = 1'b0;
    cmd_from_debug = dbg;
    cmd_wdata = c;
    cmd_wr = 1'b1;
    cyc(1);
    cmd_wr = 1'b0;
    cmd_from_debug = 1'b0;
    cyc(1);
  endtask : cmd

  task automatic wdone();
    int n = 0;
    while ((status.flash_busy_flag !== 1'b0 || status.eeprom_busy_flag !== 1'b0 ||
            cpu_halt !== 1'b0) && n < 300) begin
      cyc(1);
      n++;
    end
    ck(n < 300, 1, "operation never ended");
  endtask : wdone

  task automatic t_reset();
    rst();
    ck(&page_data, 1, "buffer not erased after reset");
    ck(|page_mark, 0, "marks after reset");
    ck(status, 0, "status after reset");
    ck(array_req, 0, "request after reset");
  endtask : t_reset

  task automatic t_and();
    rst();
    st(16'h0045, NVP_TGT_EEPROM, 8'hf0);
    st(16'h0045, NVP_TGT_EEPROM, 8'h3c);
    ck(page_data[40+:8], 8'h30, "buffer byte not anded");
    ck(page_mark[5], 1, "byte not marked");
    ck(page_mark[4], 0, "neighbour marked");
    wake_event = 1'b1;
    cyc(1);
    wake_event = 1'b0;
    cyc(1);
    ck(&page_data, 1, "buffer kept over wake");
  endtask : t_and

  task automatic t_key();
    rst();
    lat = 8'h28;
    st(16'h0100, NVP_TGT_FLASH, 8'h12);
    cmd(NVP_CMD_WRITE, 4, 1'b0);
    ck(array_req.write, 0, "command outside key window");
    cmd(NVP_CMD_WRITE, 3, 1'b0);
    ck(array_req.write, 1, "command inside window refused");
    ck(array_req.target, NVP_TGT_FLASH, "target");
    ck(array_req.addr, 16'h0100, "page address");
    ck(cpu_halt, 1, "cpu runs during flash write");
    ck(status.flash_busy_flag, 1, "flash busy missing");
    cmd(NVP_CMD_ERASE, 0, 1'b0);
    ck(array_req.erase, 0, "command taken while busy");
    ck(status.flash_busy_flag, 1, "busy dropped");
    wdone();
    ck(&page_data, 1, "buffer kept after write");
    lat = 8'h03;
  endtask : t_key

  task automatic t_ee();
    rst();
    lat = 8'h14;
    st(16'h0003, NVP_TGT_EEPROM, 8'h5a);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.eeprom_busy_flag, 1, "eeprom busy missing");
    ck(cpu_halt, 0, "cpu halted on eeprom write");
    ck(page_mark[3], 1, "marked byte lost");
    rd_valid = 1'b1;
    cyc(2);
    ck(rd_wait, 1, "no wait on busy read");
    rd_valid = 1'b0;
    wdone();
    rd_valid = 1'b1;
    cyc(2);
    ck(rd_wait, 0, "wait on idle read");
    rd_valid = 1'b0;
    lat = 8'h03;
  endtask : t_ee

  task automatic t_erase();
    int n = 0;
    rst();
    st(16'h0140, NVP_TGT_FLASH, 8'ha5);
    cmd(NVP_CMD_BUF_CLEAR, 0, 1'b0);
    wdone();
    cmd(NVP_CMD_ERASE, 0, 1'b0);
    ck(array_req.erase, 0, "erase without marked byte");
    ck(status.write_error_flag, 0, "erase refused as protected");
    st(16'h0140, NVP_TGT_FLASH, 8'ha5);
    cmd(NVP_CMD_ERASE_WRITE, 0, 1'b0);
    ck(array_req.erase, 1, "erase phase missing");
    ck(cpu_halt, 1, "cpu runs during flash erase");
    while (array_req.write !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    ck(array_req.write, 1, "write phase missing");
    ck(page_data[0+:8], 8'ha5, "buffer cleared between phases");
    wdone();
    ck(&page_data, 1, "buffer kept after erase-write");
  endtask : t_erase

  task automatic t_clear();
    int n = 0;
    rst();
    st(16'h0002, NVP_TGT_EEPROM, 8'h00);
    ccp_wr = 1'b1;
    ccp_wdata = NVP_SPM_KEY;
    cyc(1);
    ccp_wr = 1'b0;
    cmd_wdata = NVP_CMD_BUF_CLEAR;
    cmd_wr = 1'b1;
    cyc(1);
    cmd_wr = 1'b0;
    repeat (12) begin
      if (cpu_halt === 1'b1) n++;
      cyc(1);
    end
    ck(n, 7, "clear halt length");
    ck(&page_data, 1, "buffer not cleared");
  endtask : t_clear

  task automatic t_chip();
    rst();
    keep_eeprom_on_full_erase = 1'b1;
    cmd(NVP_CMD_CHIP_ERASE, 0, 1'b0);
    ck(array_req.chip, 1, "chip erase missing");
    ck(array_req.keep_eeprom, 1, "eeprom keep lost");
    wdone();
    keep_eeprom_on_full_erase = 1'b0;
    cmd(NVP_CMD_EE_ERASE, 0, 1'b0);
    ck(cpu_halt, 1, "cpu runs in eeprom erase");
    ck(status.eeprom_busy_flag, 1, "eeprom erase not busy");
    wdone();
  endtask : t_chip

  task automatic t_fuse();
    rst();
    cmd(NVP_CMD_FUSE_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "cpu fuse write taken");
    cmd(NVP_CMD_FUSE_WRITE, 0, 1'b1);
    ck(status.write_error_flag, 0, "debug fuse write refused");
    wdone();
  endtask : t_fuse

  // directional protection, locks and the user row
  task automatic t_prot();
    rst();
    exec_addr = 16'h0110;
    st(16'h0180, NVP_TGT_FLASH, 8'h01);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "program code wrote itself");
    rst();
    program_end_fuse = 8'h00;
    st(16'h0210, NVP_TGT_FLASH, 8'h02);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "storage kept with zero end fuse");
    program_end_fuse = 8'h02;
    rst();
    st(16'h0210, NVP_TGT_FLASH, 8'h02);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(array_req.write, 1, "program to storage refused");
    wdone();
    rst();
    exec_addr = 16'h0220;
    st(16'h0001, NVP_TGT_EEPROM, 8'h03);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "storage code wrote eeprom");
    rst();
    exec_addr = 16'h0010;
    st(16'h0020, NVP_TGT_FLASH, 8'h04);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "loader section written");
    rst();
    lock_wdata = 2'h3;
    lock_wr = 1'b1;
    cyc(1);
    lock_wr = 1'b0;
    cyc(1);
    ck(lock_state, 2'h3, "locks not set");
    st(16'h0100, NVP_TGT_FLASH, 8'h05);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(status.write_error_flag, 1, "locked section written");
    exec_addr = 16'h0120;
    rd_addr = 16'h0004;
    rd_is_flash = 1'b1;
    rd_valid = 1'b1;
    cyc(2);
    ck(rd_blocked, 1, "locked loader read");
    rd_valid = 1'b0;
    rst();
    ck(lock_state, 2'h0, "locks survive reset");
    device_locked = 1'b1;
    st(16'h0004, NVP_TGT_USER, 8'h11);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    ck(array_req.write, 0, "cpu wrote locked user row");
    rst();
    st_from_debug = 1'b1;
    st(16'h0004, NVP_TGT_USER, 8'h11);
    st_from_debug = 1'b0;
    cmd(NVP_CMD_WRITE, 0, 1'b1);
    ck(array_req.target, NVP_TGT_USER, "debug user row write");
    wdone();
    device_locked = 1'b0;
    exec_addr = 16'h0010;
  endtask : t_prot

  task automatic t_abort();
    rst();
    lat = 8'h28;
    st(16'h0100, NVP_TGT_FLASH, 8'h06);
    cmd(NVP_CMD_WRITE, 0, 1'b0);
    resetn = 1'b0;
    cyc(1);
    ck(array_req, 0, "write survives reset");
    rst();
    ck(status, 0, "busy after reset");
    ck(cpu_halt, 0, "halt after reset");
    lat = 8'h03;
  endtask : t_abort

  // main sequence
  initial begin
    t_reset();
    t_and();
    t_key();
    t_ee();
    t_erase();
    t_clear();
    t_chip();
    t_fuse();
    t_prot();
    t_abort();
    finish_test();
  end
endmodule : nvp_ctrl_tb
